// >>> core/awd_top.v
// Window detector with APB register file, result capture and interrupt.
// Assumes conv_done, conv_result and conv_busy come from logic on pclk;
// the converter presents conv_result already justified as left_justify says;
// software programs the limits in that same justification, nothing shifts here.
//
// Behaviour
// - Every new result word is compared against both limits, no software needed.
// - A hit sets the window flag in control register; interrupt or polling.
// - Greater-than and less-than limits are 16 bits, split high and low bytes.
// - Limit order alone selects inside-window or outside-window meaning.
// - Inside: flag when result strictly above gt and strictly below lt.
// - Outside: flag when result strictly below lower or above upper bound.
// - Results and limits compare as unsigned integers.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`include "awd_regs.vh"

// ***************************************************************
// Window detector top
// ***************************************************************
module awd_top (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // Converter result side
    input  wire        conv_done,
    input  wire [15:0] conv_result,
    input  wire        conv_busy,
    // Converter control side
    output wire        conv_enable,
    output wire        burst_enable,
    output wire [1:0]  start_mode,
    output wire        left_justify,
    output reg         conv_start,
    // Interrupt
    output wire        irq
);

    // ***************************************************************
    // Address decoding helpers
    // ***************************************************************

    // True when the byte address selects the given register index
    function is_reg;
        input [11:0] addr;
        input [9:0]  idx;
        begin
            is_reg = (addr[11:2] == idx) && (addr[1:0] == `AWD_BYTE_LANE);
        end
    endfunction

    // True when the byte address selects any mapped register
    function is_mapped;
        input [11:0] addr;
        begin
            is_mapped = is_reg(addr, `AWD_IDX_RES_LOW)  ||
                        is_reg(addr, `AWD_IDX_RES_HIGH) ||
                        is_reg(addr, `AWD_IDX_GT_LOW)   ||
                        is_reg(addr, `AWD_IDX_GT_HIGH)  ||
                        is_reg(addr, `AWD_IDX_LT_LOW)   ||
                        is_reg(addr, `AWD_IDX_LT_HIGH)  ||
                        is_reg(addr, `AWD_IDX_CTRL)     ||
                        is_reg(addr, `AWD_IDX_INT_STAT) ||
                        is_reg(addr, `AWD_IDX_INT_MASK);
        end
    endfunction

    // ***************************************************************
    // Storage
    // ***************************************************************
    // Reset values of the limits, split into byte halves below
    localparam [15:0] gt_rst_value = `AWD_GT_RST;
    localparam [15:0] lt_rst_value = `AWD_LT_RST;

    reg  [7:0]  gt_high;
    reg  [7:0]  gt_low;
    reg  [7:0]  lt_high;
    reg  [7:0]  lt_low;
    reg  [15:0] result_word;
    reg  [7:0]  ctrl;
    reg  [1:0]  int_status;
    reg  [1:0]  int_mask;

    wire        access;
    wire        mapped;
    wire        wr_en;
    wire [7:0]  wbyte;
    wire [15:0] gt_limit;
    wire [15:0] lt_limit;
    wire        win_hit;
    wire        win_event;
    wire        inside_mode;
    wire        wr_gt_high;
    wire        wr_gt_low;
    wire        wr_lt_high;
    wire        wr_lt_low;
    wire        wr_ctrl;
    wire        wr_int_stat;
    wire        wr_int_mask;

    reg  [7:0]  next_ctrl;
    reg  [1:0]  next_int_status;
    reg  [31:0] next_prdata;

    // ***************************************************************
    // APB handshake
    // ***************************************************************

    // Zero wait states; unmapped or misaligned access reports an error
    assign access  = psel & penable;
    assign mapped  = is_mapped(paddr);
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;
    assign wr_en   = access & pwrite & mapped;
    assign wbyte   = pwdata[7:0];

    // ***************************************************************
    // Write strobes
    // ***************************************************************

    // One strobe per writable register, decoded once and shared;
    // refused addresses never raise a strobe, so they change nothing
    assign wr_gt_high  = wr_en & is_reg(paddr, `AWD_IDX_GT_HIGH);
    assign wr_gt_low   = wr_en & is_reg(paddr, `AWD_IDX_GT_LOW);
    assign wr_lt_high  = wr_en & is_reg(paddr, `AWD_IDX_LT_HIGH);
    assign wr_lt_low   = wr_en & is_reg(paddr, `AWD_IDX_LT_LOW);
    assign wr_ctrl     = wr_en & is_reg(paddr, `AWD_IDX_CTRL);
    assign wr_int_stat = wr_en & is_reg(paddr, `AWD_IDX_INT_STAT);
    assign wr_int_mask = wr_en & is_reg(paddr, `AWD_IDX_INT_MASK);

    // ***************************************************************
    // Limit registers
    // ***************************************************************

    // Byte halves joined into the 16-bit limits
    assign gt_limit = {gt_high, gt_low};
    assign lt_limit = {lt_high, lt_low};

    // Greater-than limit bytes; with the reset pair the outside
    // window is empty, so nothing hits before software sets limits
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gt_high <= gt_rst_value[15:8];
            gt_low  <= gt_rst_value[7:0];
        end else begin
            if (wr_gt_high) begin
                gt_high <= wbyte;
            end
            if (wr_gt_low) begin
                gt_low <= wbyte;
            end
        end
    end

    // Less-than limit bytes; each byte stands alone, so software
    // sees a mixed limit between its two writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lt_high <= lt_rst_value[15:8];
            lt_low  <= lt_rst_value[7:0];
        end else begin
            if (wr_lt_high) begin
                lt_high <= wbyte;
            end
            if (wr_lt_low) begin
                lt_low <= wbyte;
            end
        end
    end

    // ***************************************************************
    // Window comparison
    // ***************************************************************

    // Compare the incoming word as it is written to the output registers;
    // using it rather than the captured word saves a cycle of lag
    awd_cmp u_cmp (
        .result      (conv_result),
        .gt_limit    (gt_limit),
        .lt_limit    (lt_limit),
        .inside_mode (inside_mode),
        .hit         (win_hit)
    );

    // One event per new result that lands in the window condition;
    // conv_result only counts in the cycle of conv_done
    assign win_event = conv_done & win_hit;

    // Result word capture for software reads
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_word <= `AWD_RES_RST;
        end else if (conv_done) begin
            result_word <= conv_result;
        end
    end

    // ***************************************************************
    // Converter control register
    // ***************************************************************

    // Flags clear on a written zero, and a same-cycle event wins
    always @* begin
        next_ctrl = ctrl;
        if (wr_ctrl) begin
            next_ctrl[`AWD_CTL_ENABLE]  = wbyte[`AWD_CTL_ENABLE];
            next_ctrl[`AWD_CTL_BURST]   = wbyte[`AWD_CTL_BURST];
            next_ctrl[`AWD_CTL_LJST]    = wbyte[`AWD_CTL_LJST];
            next_ctrl[`AWD_CTL_MODE_HI] = wbyte[`AWD_CTL_MODE_HI];
            next_ctrl[`AWD_CTL_MODE_LO] = wbyte[`AWD_CTL_MODE_LO];
            if (!wbyte[`AWD_CTL_DONE]) begin
                next_ctrl[`AWD_CTL_DONE] = 1'b0;
            end
            if (!wbyte[`AWD_CTL_WIN]) begin
                next_ctrl[`AWD_CTL_WIN] = 1'b0;
            end
        end
        next_ctrl[`AWD_CTL_BUSY] = 1'b0;
        if (conv_done) begin
            next_ctrl[`AWD_CTL_DONE] = 1'b1;
        end
        if (win_event) begin
            next_ctrl[`AWD_CTL_WIN] = 1'b1;
        end
    end

    // Control register state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `AWD_CTL_RST;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    // Start pulse on a written one to the busy bit while enabled;
    // enable must already stand, one write cannot enable and start
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_start <= 1'b0;
        end else begin
            conv_start <= wr_ctrl && wbyte[`AWD_CTL_BUSY] && ctrl[`AWD_CTL_ENABLE];
        end
    end

    // Control fields driven to the converter
    assign conv_enable  = ctrl[`AWD_CTL_ENABLE];
    assign burst_enable = ctrl[`AWD_CTL_BURST];
    assign start_mode   = {ctrl[`AWD_CTL_MODE_HI], ctrl[`AWD_CTL_MODE_LO]};
    assign left_justify = ctrl[`AWD_CTL_LJST];

    // ***************************************************************
    // Interrupt status and mask
    // ***************************************************************

    // Sticky bits, cleared by a written one, set wins over clear;
    // an event on the clearing edge is kept, so none is lost
    always @* begin
        next_int_status = int_status;
        if (wr_int_stat) begin
            next_int_status = int_status & ~wbyte[`AWD_INT_W-1:0];
        end
        if (win_event) begin
            next_int_status[`AWD_INT_WIN] = 1'b1;
        end
        if (conv_done) begin
            next_int_status[`AWD_INT_DONE] = 1'b1;
        end
    end

    // Status register state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status <= `AWD_INT_RST;
        end else begin
            int_status <= next_int_status;
        end
    end

    // Mask register; it gates only the level output,
    // status still records every event
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_mask <= `AWD_INT_RST;
        end else if (wr_int_mask) begin
            int_mask <= wbyte[`AWD_INT_W-1:0];
        end
    end

    // Level interrupt while any unmasked status bit is set;
    // built from flops, it drops the cycle after a clearing write
    assign irq = |(int_status & int_mask);

    // ***************************************************************
    // Read path
    // ***************************************************************

    // Read multiplexer; narrow registers sit in the low bits
    always @* begin
        next_prdata = 32'h0000_0000;
        if (is_reg(paddr, `AWD_IDX_RES_LOW)) begin
            next_prdata[7:0] = result_word[7:0];
        end else if (is_reg(paddr, `AWD_IDX_RES_HIGH)) begin
            next_prdata[7:0] = result_word[15:8];
        end else if (is_reg(paddr, `AWD_IDX_GT_LOW)) begin
            next_prdata[7:0] = gt_low;
        end else if (is_reg(paddr, `AWD_IDX_GT_HIGH)) begin
            next_prdata[7:0] = gt_high;
        end else if (is_reg(paddr, `AWD_IDX_LT_LOW)) begin
            next_prdata[7:0] = lt_low;
        end else if (is_reg(paddr, `AWD_IDX_LT_HIGH)) begin
            next_prdata[7:0] = lt_high;
        end else if (is_reg(paddr, `AWD_IDX_CTRL)) begin
            next_prdata[7:0] = ctrl;
            next_prdata[`AWD_CTL_BUSY] = conv_busy;
        end else if (is_reg(paddr, `AWD_IDX_INT_STAT)) begin
            next_prdata[`AWD_INT_W-1:0] = int_status;
        end else if (is_reg(paddr, `AWD_IDX_INT_MASK)) begin
            next_prdata[`AWD_INT_W-1:0] = int_mask;
        end
    end

    // Read data captured in the setup cycle, held through access;
    // a flag set on that same edge shows on the next read
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= next_prdata;
        end
    end

endmodule // awd_top

// >>> core/awd_regs.vh
// Register indices, field positions and reset values of the window detector.
// Assumes byte address = 4 * index on a 32-bit APB bus.
`ifndef AWD_REGS_VH
`define AWD_REGS_VH

// ***************************************************************
// Bus geometry
// ***************************************************************
`define AWD_ADDR_W        12
`define AWD_IDX_W         10
`define AWD_BYTE_LANE     2'b00

// ***************************************************************
// Register indices
// ***************************************************************
`define AWD_IDX_RES_LOW   10'h0bd
`define AWD_IDX_RES_HIGH  10'h0be
`define AWD_IDX_GT_LOW    10'h0c3
`define AWD_IDX_GT_HIGH   10'h0c4
`define AWD_IDX_LT_LOW    10'h0c5
`define AWD_IDX_LT_HIGH   10'h0c6
`define AWD_IDX_CTRL      10'h0e8
`define AWD_IDX_INT_STAT  10'h0f0
`define AWD_IDX_INT_MASK  10'h0f1

// ***************************************************************
// Converter control fields
// ***************************************************************
`define AWD_CTL_ENABLE    7
`define AWD_CTL_BURST     6
`define AWD_CTL_DONE      5
`define AWD_CTL_BUSY      4
`define AWD_CTL_WIN       3
`define AWD_CTL_LJST      2
`define AWD_CTL_MODE_HI   1
`define AWD_CTL_MODE_LO   0
`define AWD_CTL_RST       8'h00

// ***************************************************************
// Interrupt status and mask fields
// ***************************************************************
`define AWD_INT_WIN       0
`define AWD_INT_DONE      1
`define AWD_INT_W         2
`define AWD_INT_RST       2'h0

// ***************************************************************
// Limit and result reset values
// ***************************************************************
`define AWD_GT_RST        16'hffff
`define AWD_LT_RST        16'h0000
`define AWD_RES_RST       16'h0000
`define AWD_BYTE_RST      8'h00

`endif

// >>> core/awd_cmp.v
// Window comparator: decides whether one result word is a window hit.
// Assumes result and limits share one justification, all unsigned.
`timescale 1ns/1ps

// ***************************************************************
// Window comparator
// ***************************************************************
module awd_cmp (
    // Result word under test
    input  wire [15:0] result,
    // Software limits
    input  wire [15:0] gt_limit,
    input  wire [15:0] lt_limit,
    // Decision
    output wire        inside_mode,
    output wire        hit
);

    wire above_gt;
    wire below_lt;

    // Strict unsigned comparisons
    assign above_gt    = (result > gt_limit);
    assign below_lt    = (result < lt_limit);

    // Limit order alone picks inside or outside meaning
    assign inside_mode = (lt_limit > gt_limit);

    // Inside: gt < r < lt; outside: r < lt or r > gt
    assign hit = inside_mode ? (above_gt & below_lt)
                             : (above_gt | below_lt);

endmodule // awd_cmp

// >>> tb/awd_assertions.sv
// Checker of the window detector's APB, start and interrupt ports.
// Assumes it is bound onto awd_top; one clock pclk, reset presetn.
`timescale 1ns/1ps
`include "awd_regs.vh"
// *******
// Checker
// *******
module awd_assertions (
    // Clock and reset
    input wire        pclk,
    input wire        presetn,
    // APB
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        pready,
    input wire        pslverr,
    // Converter and interrupt
    input wire        conv_done,
    input wire        conv_enable,
    input wire [1:0]  start_mode,
    input wire        left_justify,
    input wire        conv_start,
    input wire        irq
);
    localparam [11:0] CT = {`AWD_IDX_CTRL, 2'b00};
    // Access cycle and control write decode
    wire acc = psel && penable;
    wire cwr = acc && pwrite && paddr == CT;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_high: assert property (acc |-> pready) else $error("pready low in access");
    a_err_access: assert property (pslverr |-> acc) else $error("pslverr outside access");
    a_err_misalign: assert property (acc && paddr[1:0] != 2'b00 |-> pslverr) else $error("misalign not refused");
    a_ctrl_write: assert property (cwr |=> conv_enable == $past(pwdata[7]) && left_justify == $past(pwdata[2])
        && start_mode == $past(pwdata[1:0])) else $error("control write lost");
    a_start_cause: assert property ($rose(conv_start) |-> $past(cwr && pwdata[4] && conv_enable))
        else $error("start without cause");
    a_start_pulse: assert property (conv_start |=> !conv_start) else $error("start too long");
    a_irq_stable: assert property (!conv_done && !(acc && pwrite) |=> $stable(irq))
        else $error("irq moved alone");
    a_irq_rise: assert property ($rose(irq) |-> $past(conv_done) || $past(acc && pwrite))
        else $error("irq rose alone");
endmodule // awd_assertions

bind awd_top awd_assertions u_awd_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .conv_done(conv_done), .conv_enable(conv_enable), .start_mode(start_mode),
    .left_justify(left_justify), .conv_start(conv_start), .irq(irq));

// >>> tb/awd_conv_model.sv
// Converter model: busy for lat+1 cycles after a start, then one done pulse.
// Assumes go and val come from the bench, conv_start from the detector.
`timescale 1ns/1ps
// *********
// Converter
// *********
module awd_conv_model (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // Start requests
    input  wire        go,
    input  wire        conv_start,
    input  wire [15:0] val,
    input  wire [3:0]  lat,
    // Result side
    output reg         conv_done,
    output reg  [15:0] conv_result,
    output reg         conv_busy
);
    reg [3:0] cnt;
    // Result toggles while idle so a stale word never looks valid
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_done   <= 1'b0;
            conv_busy   <= 1'b0;
            cnt         <= 4'h0;
            conv_result <= 16'h0000;
        end else begin
            conv_done <= 1'b0;
            if (conv_busy) begin
                if (cnt == 4'h0) begin
                    conv_busy   <= 1'b0;
                    conv_done   <= 1'b1;
                    conv_result <= val;
                end else begin
                    cnt <= cnt - 4'h1;
                end
            end else begin
                conv_result <= ~conv_result;
                if (go || conv_start) begin
                    conv_busy <= 1'b1;
                    cnt       <= lat;
                end
            end
        end
    end
endmodule // awd_conv_model

// >>> tb/tb.sv
// Bench of the window detector: APB master, converter model, self checks.
// Assumes awd_top and awd_conv_model are compiled; pclk 40 MHz.
`timescale 1ns/1ps
`include "awd_regs.vh"
// *****
// Bench
// *****
module tb;
    localparam [11:0] RL = {`AWD_IDX_RES_LOW, 2'b00};
    localparam [11:0] RH = {`AWD_IDX_RES_HIGH, 2'b00};
    localparam [11:0] GL = {`AWD_IDX_GT_LOW, 2'b00};
    localparam [11:0] GH = {`AWD_IDX_GT_HIGH, 2'b00};
    localparam [11:0] LL = {`AWD_IDX_LT_LOW, 2'b00};
    localparam [11:0] LH = {`AWD_IDX_LT_HIGH, 2'b00};
    localparam [11:0] CT = {`AWD_IDX_CTRL, 2'b00};
    localparam [11:0] ST = {`AWD_IDX_INT_STAT, 2'b00};
    localparam [11:0] MK = {`AWD_IDX_INT_MASK, 2'b00};
    reg         pclk, presetn, psel, penable, pwrite, go, e, f;
    reg  [11:0] paddr;
    reg  [31:0] pwdata;
    reg  [15:0] val, g, l;
    reg  [3:0]  lat;
    reg  [7:0]  q;
    wire [31:0] prdata;
    wire [15:0] conv_result;
    wire [1:0]  start_mode;
    wire        pready, pslverr, conv_done, conv_busy, conv_enable, burst_enable, left_justify, conv_start, irq;
    integer     mismatches = 0, n_checks = 0, cyc = 0, i, m;
    awd_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .conv_done(conv_done), .conv_result(conv_result), .conv_busy(conv_busy), .conv_enable(conv_enable),
        .burst_enable(burst_enable), .start_mode(start_mode), .left_justify(left_justify),
        .conv_start(conv_start), .irq(irq));
    awd_conv_model i_conv (.pclk(pclk), .presetn(presetn), .go(go), .conv_start(conv_start), .val(val),
        .lat(lat), .conv_done(conv_done), .conv_result(conv_result), .conv_busy(conv_busy));
    // Verdict and end of run
    task summarize;
        begin
            $display("checks %0d mismatches %0d", n_checks, mismatches);
            if (mismatches == 0 && n_checks > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    // Byte compare
    task chk(input [7:0] got, input [7:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("BAD %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    // One APB transfer; waits for pready, then releases
    task apb(input [11:0] a, input w, input [7:0] d);
        begin
            @(posedge pclk);
            psel    <= 1'b1;
            penable <= 1'b0;
            paddr   <= a;
            pwrite  <= w;
            pwdata  <= {24'h0, d};
            @(posedge pclk);
            penable <= 1'b1;
            do @(posedge pclk); while (pready !== 1'b1);
            q = prdata[7:0];
            e = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task rd(input [11:0] a, input [7:0] exp);
        begin
            apb(a, 1'b0, 8'h00);
            chk(q, exp);
        end
    endtask
    // Expected hit: ordered limits mean inside, reversed mean outside
    function hit(input [15:0] r, input [15:0] gt, input [15:0] lt);
        hit = (lt > gt) ? (r > gt && r < lt) : (r < lt || r > gt);
    endfunction
    task lim(input [15:0] gt, input [15:0] lt);
        begin
            apb(GL, 1'b1, gt[7:0]);
            apb(GH, 1'b1, gt[15:8]);
            apb(LL, 1'b1, lt[7:0]);
            apb(LH, 1'b1, lt[15:8]);
            g = gt;
            l = lt;
            rd(GH, gt[15:8]);
            rd(LL, lt[7:0]);
        end
    endtask
    // One conversion, sometimes after clearing, sometimes started by the detector
    task conv(input [15:0] r);
        reg c, s;
        integer k;
        begin
            c = $urandom;
            s = $urandom;
            val <= r;
            lat <= $urandom % 4;
            if (c) begin
                apb(ST, 1'b1, 8'h03);
                apb(CT, 1'b1, {3'b100, s, 4'h0});
                f = 1'b0;
            end
            if (!(c && s)) begin
                @(posedge pclk) go <= 1'b1;
                @(posedge pclk) go <= 1'b0;
            end
            k = 0;
            do begin @(posedge pclk); k = k + 1; end while (conv_done !== 1'b1 && k < 40);
            if (conv_done !== 1'b1) begin
                mismatches = mismatches + 1;
                $display("BAD %0t conversion never finished", $time);
            end
            f = f | hit(r, g, l);
            rd(CT, {4'ha, f, 3'b000});
            rd(RL, r[7:0]);
            rd(RH, r[15:8]);
            chk({7'h0, irq}, {7'h0, f});
        end
    endtask
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // Hang guard
    always @(posedge pclk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            mismatches = mismatches + 1;
            summarize;
        end
    end
    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, go, e, f, paddr, pwdata, val, lat} = 0;
        i = $urandom(32'hf064);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(GL, 8'hff);
        rd(GH, 8'hff);
        rd(LH, 8'h00);
        rd(CT, 8'h00);
        rd(ST, 8'h00);
        rd(RH, 8'h00);
        apb(12'h004, 1'b0, 8'h00);
        chk({q[6:0], e}, 8'h01);
        apb(LL + 12'h001, 1'b1, 8'h5a);
        rd(LL, 8'h00);
        apb(MK, 1'b1, 8'h01);
        rd(MK, 8'h01);
        apb(CT, 1'b1, 8'h80);
        $display("test reset done");
        for (m = 0; m < 3; m = m + 1) begin
            if (m < 2)
                lim(16'h0100 << m, 16'h0200 >> m);
            else
                lim($urandom, $urandom);
            for (i = 0; i < 12; i = m + i + 1)
                conv((m < 2 && i < 6) ? (i < 3 ? 16'h0100 : 16'h0200) + i % 3 - 1
                                      : $urandom % (m < 2 ? 4096 : 65536));
            $display("test window %0d done", m);
        end
        lim(16'h0100, 16'h0200);
        conv(16'h0150);
        apb(MK, 1'b1, 8'h00);
        @(posedge pclk);
        chk({7'h0, irq}, 8'h00);
        rd(ST, 8'h03);
        apb(ST, 1'b1, 8'h03);
        rd(ST, 8'h00);
        $display("test interrupt done");
        apb(CT, 1'b1, 8'hc7);
        @(posedge pclk);
        chk({3'h0, conv_enable, burst_enable, left_justify, start_mode}, 8'h1f);
        rd(CT, 8'hc7);
        $display("test control done");
        summarize;
    end
endmodule // tb
